// ### las_link_ack_status_regs.sv
// acknowledge status register bank with AXI4-Lite slave and interrupt
//
// What this block does
// - Offset zero reads fixed identity word: part number low half, step number high half.
// - Control acknowledge register keeps last ack for control transmit FIFO packets.
// - Control ack code sits in bits 23 to 27, loaded from transmitter report.
// - Top bit zero means ordinary four-bit bus ack code follows.
// - Ack timeout records top bit one with code 0000.
// - Ack packet longer than eight bits records top bit one, code 0001.
// - Ack packet shorter than eight bits records top bit one, code 0010.
// - Bit 31 control fresh flag sets whenever a new ack is loaded.
// - Software read of control register clears its fresh flag.
// - Control field and flag writable only while write unlock bit is one.
// - Power-up or software reset clears both ack registers to zero.
// - Bulk acknowledge register keeps last ack for bulky transmit FIFO packets.
// - Bulk ack code uses bits 23 to 27 with the same encoding.
// - Bit 31 bulk fresh flag sets whenever a new bulk ack is loaded; a read of the bulk register clears it.
// - Bulk field and flag writable only while write unlock bit is one.
`timescale 1ns/1ps
`default_nettype none
module las_link_ack_status_regs
	import las_pkg::*;
#(
	parameter logic [15:0] PART_NUMBER = 16'hA5A5, // arbitrary value
	parameter logic [15:0] STEP_NUMBER = 16'h0001 // arbitrary value
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic softReset,
	input wire las_ack_rpt_t ctrlAckRpt,
	input wire las_ack_rpt_t bulkAckRpt,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic statusWriteUnlock,
	output logic irq
);
	// 5-bit ack value, bit 4 is the kind flag placed at bit 23
	function automatic logic [4:0] encodeAck(input las_ack_rpt_t r);
		logic [4:0] v;
		v = {1'b1, LAS_CODE_TIMEOUT};
		case (r.kind)
			LAS_ACK_NORMAL: v = {1'b0, r.code};
			LAS_ACK_TIMEOUT: v = {1'b1, LAS_CODE_TIMEOUT};
			LAS_ACK_TOO_LONG: v = {1'b1, LAS_CODE_TOO_LONG};
			LAS_ACK_TOO_SHORT: v = {1'b1, LAS_CODE_TOO_SHORT};
			default: v = {1'b1, LAS_CODE_TIMEOUT};
		endcase
		return v;
	endfunction

	// flag at bit 23, four-bit code msb first in bits 24..27
	function automatic logic [31:0] placeAck(input logic [4:0] v, input logic fresh);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[LAS_ACK_LSB] = v[4];
		w[LAS_ACK_LSB + 1] = v[3];
		w[LAS_ACK_LSB + 2] = v[2];
		w[LAS_ACK_LSB + 3] = v[1];
		w[LAS_ACK_MSB] = v[0];
		w[LAS_FRESH_BIT] = fresh;
		return w;
	endfunction

	function automatic logic [4:0] takeAck(input logic [31:0] w);
		logic [4:0] v;
		v[4] = w[LAS_ACK_LSB];
		v[3] = w[LAS_ACK_LSB + 1];
		v[2] = w[LAS_ACK_LSB + 2];
		v[1] = w[LAS_ACK_LSB + 3];
		v[0] = w[LAS_ACK_MSB];
		return v;
	endfunction

	function automatic logic [31:0] strbMask(input logic [3:0] s);
		logic [31:0] m;
		for (int i = 0; i < 4; i++) begin
			m[8 * i +: 8] = {8{s[i]}};
		end
		return m;
	endfunction

	// byte-lane merge of a register image with the held write data
	function automatic logic [31:0] mergeWrite(input logic [31:0] img, input logic [31:0] nw, input logic [3:0] s);
		logic [31:0] m;
		m = strbMask(s);
		return (img & ~m) | (nw & m);
	endfunction

	logic [11:0] awAddr_q;
	logic awHeld_q;
	logic awReady_q;
	logic [31:0] wData_q;
	logic [3:0] wStrb_q;
	logic wHeld_q;
	logic wReady_q;
	logic bValid_q;
	logic [1:0] bResp_q;
	logic arReady_q;
	logic rValid_q;
	logic [31:0] rData_q;
	logic [1:0] rResp_q;
	logic [4:0] ctrlAck_q;
	logic ctrlFresh_q;
	logic [4:0] bulkAck_q;
	logic bulkFresh_q;
	logic unlock_q;
	logic [1:0] irqStat_q;
	logic [1:0] irqMask_q;
	logic irq_q;

	logic doWrite;
	logic doRead;
	logic [31:0] ctrlMerged;
	logic [31:0] bulkMerged;
	logic wrCtrl;
	logic wrBulk;
	logic wrUnlock;
	logic wrIrqStat;
	logic wrIrqMask;
	logic rdCtrl;
	logic rdBulk;

	// a write lands once both halves are held and the last answer is gone
	assign doWrite = awHeld_q && wHeld_q && !bValid_q;
	assign doRead = s_axi_arvalid && arReady_q;
	assign ctrlMerged = mergeWrite(placeAck(ctrlAck_q, ctrlFresh_q), wData_q, wStrb_q);
	assign bulkMerged = mergeWrite(placeAck(bulkAck_q, bulkFresh_q), wData_q, wStrb_q);
	assign wrCtrl = doWrite && unlock_q && awAddr_q == LAS_CTRL_ACK_STATUS_OFS;
	assign wrBulk = doWrite && unlock_q && awAddr_q == LAS_BACK_OFS;
	assign wrUnlock = doWrite && awAddr_q == LAS_TEST_OFS && wStrb_q[0];
	assign wrIrqStat = doWrite && awAddr_q == LAS_IRQ_STAT_OFS && wStrb_q[0];
	assign wrIrqMask = doWrite && awAddr_q == LAS_IRQ_MASK_OFS && wStrb_q[0];
	assign rdCtrl = doRead && s_axi_araddr == LAS_CTRL_ACK_STATUS_OFS;
	assign rdBulk = doRead && s_axi_araddr == LAS_BACK_OFS;

	// write address and data latches, taken in either order
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			awHeld_q <= 1'b0;
			awReady_q <= 1'b1;
		end else if (s_axi_awvalid && awReady_q) begin
			awHeld_q <= 1'b1;
			awReady_q <= 1'b0;
		end else if (doWrite) begin
			awHeld_q <= 1'b0;
			awReady_q <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			awAddr_q <= 12'h000;
		end else if (s_axi_awvalid && awReady_q) begin
			awAddr_q <= s_axi_awaddr;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			wHeld_q <= 1'b0;
			wReady_q <= 1'b1;
		end else if (s_axi_wvalid && wReady_q) begin
			wHeld_q <= 1'b1;
			wReady_q <= 1'b0;
		end else if (doWrite) begin
			wHeld_q <= 1'b0;
			wReady_q <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			wData_q <= 32'h0000_0000;
			wStrb_q <= 4'h0;
		end else if (s_axi_wvalid && wReady_q) begin
			wData_q <= s_axi_wdata;
			wStrb_q <= s_axi_wstrb;
		end
	end

	// write response
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			bValid_q <= 1'b0;
		end else if (doWrite) begin
			bValid_q <= 1'b1;
		end else if (s_axi_bready) begin
			bValid_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			bResp_q <= LAS_RESP_OKAY;
		end else if (doWrite) begin
			case (awAddr_q)
				LAS_IDENT_OFS, LAS_CTRL_ACK_STATUS_OFS, LAS_BACK_OFS, LAS_TEST_OFS,
				LAS_IRQ_STAT_OFS, LAS_IRQ_MASK_OFS: bResp_q <= LAS_RESP_OKAY;
				default: bResp_q <= LAS_RESP_SLVERR;
			endcase
		end
	end

	// read channel; one read in flight
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			arReady_q <= 1'b1;
		end else if (doRead) begin
			arReady_q <= 1'b0;
		end else if (rValid_q && s_axi_rready) begin
			arReady_q <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rValid_q <= 1'b0;
		end else if (doRead) begin
			rValid_q <= 1'b1;
		end else if (rValid_q && s_axi_rready) begin
			rValid_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rData_q <= 32'h0000_0000;
			rResp_q <= LAS_RESP_OKAY;
		end else if (doRead) begin
			rResp_q <= LAS_RESP_OKAY;
			case (s_axi_araddr)
				LAS_IDENT_OFS: rData_q <= {STEP_NUMBER, PART_NUMBER};
				LAS_CTRL_ACK_STATUS_OFS: rData_q <= placeAck(ctrlAck_q, ctrlFresh_q);
				LAS_BACK_OFS: rData_q <= placeAck(bulkAck_q, bulkFresh_q);
				LAS_TEST_OFS: rData_q <= {31'h0000_0000, unlock_q};
				LAS_IRQ_STAT_OFS: rData_q <= {30'h0000_0000, irqStat_q};
				LAS_IRQ_MASK_OFS: rData_q <= {30'h0000_0000, irqMask_q};
				default: begin
					rData_q <= 32'h0000_0000;
					rResp_q <= LAS_RESP_SLVERR;
				end
			endcase
		end
	end

	// control acknowledge field
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrlAck_q <= LAS_ACK_RESET;
		end else if (softReset) begin
			ctrlAck_q <= LAS_ACK_RESET;
		end else if (ctrlAckRpt.strobe) begin
			ctrlAck_q <= encodeAck(ctrlAckRpt);
		end else if (wrCtrl) begin
			ctrlAck_q <= takeAck(ctrlMerged);
		end
	end

	// control fresh flag; a capture beats a clear by read
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrlFresh_q <= 1'b0;
		end else if (softReset) begin
			ctrlFresh_q <= 1'b0;
		end else if (ctrlAckRpt.strobe) begin
			ctrlFresh_q <= 1'b1;
		end else if (wrCtrl) begin
			ctrlFresh_q <= ctrlMerged[LAS_FRESH_BIT];
		end else if (rdCtrl) begin
			ctrlFresh_q <= 1'b0;
		end
	end

	// bulk acknowledge field
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			bulkAck_q <= LAS_ACK_RESET;
		end else if (softReset) begin
			bulkAck_q <= LAS_ACK_RESET;
		end else if (bulkAckRpt.strobe) begin
			bulkAck_q <= encodeAck(bulkAckRpt);
		end else if (wrBulk) begin
			bulkAck_q <= takeAck(bulkMerged);
		end
	end

	// bulk fresh flag; a capture beats a clear by read
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			bulkFresh_q <= 1'b0;
		end else if (softReset) begin
			bulkFresh_q <= 1'b0;
		end else if (bulkAckRpt.strobe) begin
			bulkFresh_q <= 1'b1;
		end else if (wrBulk) begin
			bulkFresh_q <= bulkMerged[LAS_FRESH_BIT];
		end else if (rdBulk) begin
			bulkFresh_q <= 1'b0;
		end
	end

	// diagnostics unlock bit
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			unlock_q <= 1'b0;
		end else if (softReset) begin
			unlock_q <= 1'b0;
		end else if (wrUnlock) begin
			unlock_q <= wData_q[LAS_UNLOCK_BIT];
		end
	end

	// interrupt status, write one to clear, new capture wins
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			irqStat_q <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if ((i == LAS_IRQ_CTRL_BIT && ctrlAckRpt.strobe) || (i == LAS_IRQ_BULK_BIT && bulkAckRpt.strobe)) begin
					irqStat_q[i] <= 1'b1;
				end else if (wrIrqStat && wData_q[i]) begin
					irqStat_q[i] <= 1'b0;
				end
			end
		end
	end

	// interrupt mask, same layout as the status
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			irqMask_q <= 2'h0;
		end else if (wrIrqMask) begin
			irqMask_q <= wData_q[1:0];
		end
	end

	// level interrupt, registered so the pin comes from a flop
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irqStat_q & irqMask_q);
		end
	end

	assign s_axi_awready = awReady_q;
	assign s_axi_wready = wReady_q;
	assign s_axi_bvalid = bValid_q;
	assign s_axi_bresp = bResp_q;
	assign s_axi_arready = arReady_q;
	assign s_axi_rvalid = rValid_q;
	assign s_axi_rdata = rData_q;
	assign s_axi_rresp = rResp_q;
	assign statusWriteUnlock = unlock_q;
	assign irq = irq_q;
endmodule
`default_nettype wire

// ### las_pkg.sv
// constants and types for the acknowledge status register bank
package las_pkg;
	localparam logic [11:0] LAS_IDENT_OFS = 12'h000;
	localparam logic [11:0] LAS_CTRL_ACK_STATUS_OFS = 12'h004;
	localparam logic [11:0] LAS_BACK_OFS = 12'h008;
	localparam logic [11:0] LAS_TEST_OFS = 12'h030;
	localparam logic [11:0] LAS_IRQ_STAT_OFS = 12'h040;
	localparam logic [11:0] LAS_IRQ_MASK_OFS = 12'h044;
	localparam int LAS_PART_LSB = 0;
	localparam int LAS_STEP_LSB = 16;
	localparam int LAS_ACK_LSB = 23;
	localparam int LAS_ACK_MSB = 27;
	localparam int LAS_FRESH_BIT = 31;
	localparam int LAS_UNLOCK_BIT = 0;
	localparam int LAS_IRQ_CTRL_BIT = 0;
	localparam int LAS_IRQ_BULK_BIT = 1;
	localparam logic [4:0] LAS_ACK_RESET = 5'h00;
	localparam logic [3:0] LAS_CODE_TIMEOUT = 4'h0;
	localparam logic [3:0] LAS_CODE_TOO_LONG = 4'h1;
	localparam logic [3:0] LAS_CODE_TOO_SHORT = 4'h2;
	localparam logic [1:0] LAS_RESP_OKAY = 2'h0;
	localparam logic [1:0] LAS_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		LAS_ACK_NORMAL,
		LAS_ACK_TIMEOUT,
		LAS_ACK_TOO_LONG,
		LAS_ACK_TOO_SHORT
	} las_ack_kind_t;

	// one acknowledge report from the link transmitter
	typedef struct packed {
		logic strobe;
		las_ack_kind_t kind;
		logic [3:0] code;
	} las_ack_rpt_t;
endpackage

// ### las_link_ack_status_regs_chk.sv
// assertion checker for the acknowledge status register bank
`timescale 1ns/1ps
`default_nettype none
module las_link_ack_status_regs_chk
	import las_pkg::*;
#(
	parameter logic [15:0] PART_NUMBER = 16'hA5A5,
	parameter logic [15:0] STEP_NUMBER = 16'h0001
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic softReset,
	input wire las_ack_rpt_t ctrlAckRpt,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic statusWriteUnlock
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	logic arTake;
	assign arTake = s_axi_arvalid && s_axi_arready;
	ident_read_a: assert property (arTake && s_axi_araddr == LAS_IDENT_OFS |=>
		s_axi_rvalid && s_axi_rdata == {STEP_NUMBER, PART_NUMBER}) else $error("identity word wrong");
	read_answer_a: assert property (arTake |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
	bad_addr_a: assert property (arTake && s_axi_araddr == 12'h00C |=>
		s_axi_rresp == LAS_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
	fresh_after_ack_a: assert property (ctrlAckRpt.strobe && !softReset ##1
		arTake && s_axi_araddr == LAS_CTRL_ACK_STATUS_OFS |=> s_axi_rdata[LAS_FRESH_BIT]) else $error("fresh flag missing");
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=>
		!s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer timing wrong");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	unlock_clear_a: assert property (softReset |=> !statusWriteUnlock) else $error("unlock kept");
endmodule
`default_nettype wire

// ### test_las_link_ack_status_regs.sv
// self-checking bench for the acknowledge status register bank
`timescale 1ns/1ps
`default_nettype none
module test_las_link_ack_status_regs import las_pkg::*;;
	logic ref_clk = 0, reset_n = 0, softReset = 0, irq, statusWriteUnlock;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0, a;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, e;
	logic [3:0] s_axi_wstrb = 4'hF, c;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, b;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	las_ack_rpt_t ctrlAckRpt = '0, bulkAckRpt = '0;
	las_ack_kind_t k;
	int errors = 0, comparisons = 0, seed = 32'h2CA6;
	always #50 ref_clk = ~ref_clk;
	las_link_ack_status_regs u_las_link_ack_status_regs (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.softReset(softReset),
		.ctrlAckRpt(ctrlAckRpt),
		.bulkAckRpt(bulkAckRpt),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.statusWriteUnlock(statusWriteUnlock),
		.irq(irq)
	);
	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task stop_test;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	function automatic logic [31:0] ackWord(input las_ack_kind_t kk, input logic [3:0] cc);
		logic [4:0] v;
		logic [31:0] w;
		v = kk == LAS_ACK_NORMAL ? {1'b0, cc} : {1'b1, kk == LAS_ACK_TIMEOUT ? LAS_CODE_TIMEOUT :
			kk == LAS_ACK_TOO_LONG ? LAS_CODE_TOO_LONG : LAS_CODE_TOO_SHORT};
		w = 32'h80000000;
		for (int i = 0; i < 5; i++) w[LAS_ACK_LSB + i] = v[4 - i];
		return w;
	endfunction
	task ack(input logic bk, input las_ack_kind_t kk, input logic [3:0] cc);
		@(posedge ref_clk);
		if (bk) bulkAckRpt <= '{1'b1, kk, cc};
		else ctrlAckRpt <= '{1'b1, kk, cc};
	endtask
	// one read (w=0) or write (w=1); ca fires a control ack at the read take
	task xfer(input bit w, input logic [11:0] ad, input logic [31:0] v, input bit ca = 0);
		int i;
		@(posedge ref_clk);
		if (w) begin
			s_axi_awaddr <= ad;
			s_axi_wdata <= v;
			s_axi_awvalid <= 1;
			s_axi_wvalid <= 1;
		end else begin
			s_axi_araddr <= ad;
			s_axi_arvalid <= 1;
		end
		if (ca) ctrlAckRpt <= '{1'b1, LAS_ACK_NORMAL, v[3:0]};
		else ctrlAckRpt.strobe <= 0;
		bulkAckRpt.strobe <= 0;
		for (i = 0; i < 50; i++) begin
			@(posedge ref_clk);
			ctrlAckRpt.strobe <= 0;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
			if (w ? s_axi_bvalid && s_axi_bready : s_axi_rvalid && s_axi_rready) break;
			s_axi_bready <= s_axi_bvalid;
			s_axi_rready <= s_axi_rvalid;
		end
		d = s_axi_rdata;
		r = w ? s_axi_bresp : s_axi_rresp;
		s_axi_bready <= 0;
		s_axi_rready <= 0;
		if (i == 50) begin
			errors++;
			stop_test;
		end
	endtask
	initial begin
		repeat (20) @(posedge ref_clk);
		reset_n <= 1;
		xfer(0, LAS_IDENT_OFS, 0);
		check(d, 32'h0001A5A5);
		for (int n = 0; n < 18; n++) begin
			b = n[0];
			k = las_ack_kind_t'(n[2:1]);
			c = 4'($random(seed));
			a = b ? LAS_BACK_OFS : LAS_CTRL_ACK_STATUS_OFS;
			if (n < 2) xfer(0, a, 0);
			if (n < 2) check(d, 32'h0);
			ack(b, k, c);
			xfer(0, a, 0);
			check(d, ackWord(k, c));
			xfer(0, a, 0);
			check(d, ackWord(k, c) & 32'h7FFFFFFF);
		end
		for (int n = 0; n < 4; n++) begin
			a = n[0] ? LAS_BACK_OFS : LAS_CTRL_ACK_STATUS_OFS;
			if (n == 2) xfer(1, LAS_TEST_OFS, 32'h1);
			xfer(0, a, 0);
			e = n[1] ? 32'h8F800000 : d;
			xfer(1, a, 32'h8F800000);
			xfer(0, a, 0);
			check(d, e);
		end
		check(32'(statusWriteUnlock), 32'h1);
		s_axi_wstrb <= 4'h7;
		xfer(1, LAS_CTRL_ACK_STATUS_OFS, 32'h0);
		s_axi_wstrb <= 4'hF;
		xfer(0, LAS_CTRL_ACK_STATUS_OFS, 0);
		check(d, 32'h0F000000);
		xfer(0, LAS_CTRL_ACK_STATUS_OFS, 32'h5, 1);
		xfer(0, LAS_CTRL_ACK_STATUS_OFS, 0);
		check(d, ackWord(LAS_ACK_NORMAL, 4'h5));
		xfer(0, 12'h00C, 0);
		check(32'(r), 32'(LAS_RESP_SLVERR));
		xfer(1, 12'h00C, 0);
		check(32'(r), 32'(LAS_RESP_SLVERR));
		ack(1, LAS_ACK_NORMAL, 4'h3);
		xfer(0, LAS_IRQ_STAT_OFS, 0);
		check(d, 32'h3);
		check(32'(irq), 32'h0);
		xfer(1, LAS_IRQ_MASK_OFS, 32'h2);
		repeat (2) @(posedge ref_clk);
		check(32'(irq), 32'h1);
		xfer(1, LAS_IRQ_STAT_OFS, 32'h2);
		repeat (2) @(posedge ref_clk);
		check(32'(irq), 32'h0);
		@(posedge ref_clk);
		softReset <= 1;
		@(posedge ref_clk);
		softReset <= 0;
		xfer(0, LAS_CTRL_ACK_STATUS_OFS, 0);
		check(d, 32'h0);
		check(32'(statusWriteUnlock), 32'h0);
		stop_test;
	end
endmodule
bind las_link_ack_status_regs las_link_ack_status_regs_chk #(
	.PART_NUMBER(PART_NUMBER),
	.STEP_NUMBER(STEP_NUMBER)
) u_las_link_ack_status_regs_chk (
	.ref_clk(ref_clk),
	.reset_n(reset_n),
	.softReset(softReset),
	.ctrlAckRpt(ctrlAckRpt),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.statusWriteUnlock(statusWriteUnlock)
);
`default_nettype wire
